// ### src/dual_wiper_register_bank.sv
// dual wiper register bank with serial slave link and tap decode
`timescale 1ns/10ps
`include "wiper_bank_regs.svh"
module dual_wiper_register_bank #(
  parameter logic [2:0] FIXED_ADDR = `DEV_ADDR_FIXED  // upper address bits
) (
  // clock and reset
  input  logic                        clk,
  input  logic                        rst_b,
  // serial link pins
  input  logic                        sclIn,
  input  logic                        sdaIn,
  output logic                        sdaOut,
  output logic                        sdaOe_b,
  // address select straps
  input  logic                        addrSelectBitZero,
  input  logic                        addrSelectBitOne,
  input  logic                        addrSelectBitTwo,
  input  logic                        addrSelectBitThree,
  // wiper state
  output wiper_bank_pkg::wiper_pos_t  wiperPosPot0,
  output wiper_bank_pkg::wiper_pos_t  wiperPosPot1,
  output logic [`TAP_COUNT-1:0]       tapSelPot0,
  output logic [`TAP_COUNT-1:0]       tapSelPot1
);
  import wiper_bank_pkg::*;

  // --------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------
  logic        sclMeta_reg, sclSync_reg, sclPrev_reg;   // clock pin synchroniser
  logic        sdaMeta_reg, sdaSync_reg, sdaPrev_reg;   // data pin synchroniser
  logic [3:0]  addrMeta_reg, addrSync_reg;              // strap synchroniser
  wiper_pos_t  wiperReg [2];                            // live wiper codes
  wiper_pos_t  storedReg [2][4];                        // stored settings
  logic        bootPending_reg;                         // recall after reset
  link_state_t state_reg, state_next;                   // link engine state
  logic [3:0]  bitCnt_reg, bitCnt_next;                 // bits of current byte
  logic [1:0]  byteCnt_reg, byteCnt_next;               // 0 addr, 1 instr, 2 data
  logic [7:0]  shift_reg, shift_next;                   // receive shifter
  logic [7:0]  txShift_reg, txShift_next;               // transmit shifter
  logic [7:0]  instr_reg, instr_next;                   // latched instruction
  logic        readMode_reg, readMode_next;             // read transaction
  logic        sdaOe_b_reg, sdaOe_b_next;               // low pulls line low

  wiper_link_if wiperLink ();

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {sclMeta_reg, sclSync_reg, sclPrev_reg} <= 3'h7;
      {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= 3'h7;
    end else begin
      {sclMeta_reg, sclSync_reg, sclPrev_reg} <= {sclIn, sclMeta_reg, sclSync_reg};
      {sdaMeta_reg, sdaSync_reg, sdaPrev_reg} <= {sdaIn, sdaMeta_reg, sdaSync_reg};
    end
  end

  // straps, bit zero is the least significant
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrMeta_reg <= 4'h0;
      addrSync_reg <= 4'h0;
    end else begin
      addrMeta_reg <= {addrSelectBitThree, addrSelectBitTwo,
                       addrSelectBitOne, addrSelectBitZero};
      addrSync_reg <= addrMeta_reg;
    end
  end

  // --------------------------------------------------------------------
  // link event decode: bits timed by the master's clock edges, start and stop by data edges while clock high
  // --------------------------------------------------------------------
  wire sclRise   = sclSync_reg & ~sclPrev_reg;
  wire sclFall   = ~sclSync_reg & sclPrev_reg;
  wire startSeen = sclSync_reg & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg;
  wire stopSeen  = sclSync_reg & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg;
  wire byteDone  = (state_reg == LINK_RX) & sclFall & (bitCnt_reg == 4'h8);
  wire isAddr    = (byteCnt_reg == 2'h0);
  wire isInstr   = (byteCnt_reg == 2'h1);
  wire isData    = (byteCnt_reg == 2'h2);
  wire addrMatch = (shift_reg[7:1] == {FIXED_ADDR, addrSync_reg});

  // fields of the latched and the just-received instruction
  wire op_code_t   opCode  = instr_reg[`INSTR_OP_MSB:`INSTR_OP_LSB];
  wire [1:0]       slotSel = instr_reg[`INSTR_SLOT_MSB:`INSTR_SLOT_LSB];
  wire             potSel  = instr_reg[`INSTR_POT_BIT];
  wire op_code_t   newOp   = shift_reg[`INSTR_OP_MSB:`INSTR_OP_LSB];
  wire [1:0]       newSlot = shift_reg[`INSTR_SLOT_MSB:`INSTR_SLOT_LSB];
  wire             newPot  = shift_reg[`INSTR_POT_BIT];
  wire wiper_pos_t dataIn  = shift_reg[`WIPER_W-1:0];

  // register actions, only ever caused by link traffic
  wire dataWrite  = byteDone & isData & ~readMode_reg;
  wire wrWiper    = dataWrite & (opCode == `OP_WR_WIPER);
  wire wrStored   = dataWrite & (opCode == `OP_WR_STORED);
  wire stepWiper  = dataWrite & (opCode == `OP_STEP);
  wire stepUp     = shift_reg[`STEP_UP_BIT];
  wire recallNow  = byteDone & isInstr & (newOp == `OP_RECALL);
  wire saveNow    = byteDone & isInstr & (newOp == `OP_SAVE);

  // read data: stored slot or live wiper, upper bits zero
  wire [7:0] txData = (opCode == `OP_RD_STORED) ? {2'h0, storedReg[potSel][slotSel]}
                                                : {2'h0, wiperReg[potSel]};

  // --------------------------------------------------------------------
  // register storage, one generate branch per pot and slot
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bootPending_reg <= 1'b1;
    end else begin
      bootPending_reg <= 1'b0;
    end
  end

  genvar p, s;
  generate
    for (p = 0; p < 2; p++) begin : g_pot
      // saturating step target
      wire wiper_pos_t stepTarget =
        (stepUp && wiperReg[p] != `WIPER_MAX) ? wiper_pos_t'(wiperReg[p] + 6'h01) :
        (!stepUp && wiperReg[p] != 6'h00)     ? wiper_pos_t'(wiperReg[p] - 6'h01) :
                                                wiperReg[p];
      // each pot's wiper moves on the boot recall of slot zero or on its own selection
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          wiperReg[p] <= `WIPER_RESET;
        end else if (bootPending_reg) begin
          wiperReg[p] <= storedReg[p][0];
        end else if (recallNow && newPot == p) begin
          wiperReg[p] <= storedReg[p][newSlot];
        end else if (wrWiper && potSel == p) begin
          wiperReg[p] <= dataIn;
        end else if (stepWiper && potSel == p) begin
          wiperReg[p] <= stepTarget;
        end
      end

      for (s = 0; s < 4; s++) begin : g_slot
        // stored slot: saved from wiper or written over the link
        always_ff @(posedge clk or negedge rst_b) begin
          if (!rst_b) begin
            storedReg[p][s] <= `STORED_RESET;
          end else if (saveNow && newPot == p && newSlot == s) begin
            storedReg[p][s] <= wiperReg[p];
          end else if (wrStored && potSel == p && slotSel == s) begin
            storedReg[p][s] <= dataIn;
          end
        end
      end

      assign wiperLink.pos[p] = wiperReg[p];
    end
  endgenerate

  // --------------------------------------------------------------------
  // link engine next state
  // --------------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    bitCnt_next   = bitCnt_reg;
    byteCnt_next  = byteCnt_reg;
    shift_next    = shift_reg;
    txShift_next  = txShift_reg;
    instr_next    = instr_reg;
    readMode_next = readMode_reg;
    sdaOe_b_next  = sdaOe_b_reg;
    if (startSeen) begin
      // start or repeated start
      state_next   = LINK_RX;
      bitCnt_next  = 4'h0;
      byteCnt_next = 2'h0;
      sdaOe_b_next = 1'b1;
    end else if (stopSeen) begin
      // stop ends every transaction
      state_next   = LINK_IDLE;
      sdaOe_b_next = 1'b1;
    end else begin
      case (state_reg)
        LINK_RX: begin
          if (sclRise) begin
            shift_next  = {shift_reg[6:0], sdaSync_reg};
            bitCnt_next = 4'(bitCnt_reg + 4'h1);
          end else if (byteDone) begin
            if (isAddr && !addrMatch) begin
              state_next = LINK_IDLE;
            end else begin
              state_next   = LINK_ACK;
              sdaOe_b_next = 1'b0;
              byteCnt_next = isData ? 2'h2 : 2'(byteCnt_reg + 2'h1);
              if (isAddr) begin
                readMode_next = shift_reg[0];
              end
              if (isInstr) begin
                instr_next = shift_reg;
              end
            end
          end
        end
        LINK_ACK: begin
          if (sclFall) begin
            bitCnt_next = 4'h0;
            if (readMode_reg) begin
              state_next   = LINK_TX;
              txShift_next = txData;
              sdaOe_b_next = txData[7];
            end else begin
              state_next   = LINK_RX;
              sdaOe_b_next = 1'b1;
            end
          end
        end
        LINK_TX: begin
          if (sclRise) begin
            bitCnt_next = 4'(bitCnt_reg + 4'h1);
          end else if (sclFall) begin
            if (bitCnt_reg == 4'h8) begin
              state_next   = LINK_TXACK;
              sdaOe_b_next = 1'b1;
            end else begin
              txShift_next = {txShift_reg[6:0], 1'b0};
              sdaOe_b_next = txShift_reg[6];
            end
          end
        end
        LINK_TXACK: begin
          // master acknowledge asks for another byte, no-ack ends
          if (sclRise) begin
            state_next = sdaSync_reg ? LINK_IDLE : LINK_ACK;
          end
        end
        default: begin
          state_next   = LINK_IDLE;
          sdaOe_b_next = 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // link engine registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= LINK_IDLE;
      bitCnt_reg   <= 4'h0;
      byteCnt_reg  <= 2'h0;
      shift_reg    <= 8'h00;
      txShift_reg  <= 8'h00;
      instr_reg    <= 8'h00;
      readMode_reg <= 1'b0;
      sdaOe_b_reg  <= 1'b1;
    end else begin
      state_reg    <= state_next;
      bitCnt_reg   <= bitCnt_next;
      byteCnt_reg  <= byteCnt_next;
      shift_reg    <= shift_next;
      txShift_reg  <= txShift_next;
      instr_reg    <= instr_next;
      readMode_reg <= readMode_next;
      sdaOe_b_reg  <= sdaOe_b_next;
    end
  end

  // --------------------------------------------------------------------
  // outputs and tap decode
  // --------------------------------------------------------------------
  assign sdaOut       = 1'b0;  // open drain: only ever pulls low
  assign sdaOe_b      = sdaOe_b_reg;
  assign wiperPosPot0 = wiperReg[0];
  assign wiperPosPot1 = wiperReg[1];

  tap_decoder u_tap_decoder (
    .clk        (clk),
    .rst_b      (rst_b),
    .link       (wiperLink.decoder),
    .tapSelPot0 (tapSelPot0),
    .tapSelPot1 (tapSelPot1)
  );

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence addrRejected;
    byteDone && isAddr && !addrMatch && !startSeen && !stopSeen;
  endsequence
  sequence addrAccepted;
    byteDone && isAddr && addrMatch && !startSeen && !stopSeen;
  endsequence

  a_boot_recall: assert property (bootPending_reg |=>
    wiperReg[0] == $past(storedReg[0][0]) && wiperReg[1] == $past(storedReg[1][0]))
    else $error("slot zero not recalled after reset");
  a_addr_reject: assert property (addrRejected |=>
    state_reg == LINK_IDLE && sdaOe_b_reg ##1 sdaOe_b_reg)
    else $error("foreign address not ignored");
  a_addr_ack: assert property (addrAccepted |=>
    state_reg == LINK_ACK && !sdaOe_b_reg)
    else $error("own address not acknowledged");
  a_wiper_write: assert property (wrWiper && !potSel |=>
    wiperReg[0] == $past(dataIn) && $stable(wiperReg[1]))
    else $error("wiper write wrong or touched other pot");
  a_stored_write: assert property (wrStored && !saveNow |=>
    storedReg[$past(potSel)][$past(slotSel)] == $past(dataIn))
    else $error("stored slot not written");
  a_link_only: assert property ($changed(wiperReg[0]) |->
    $past(bootPending_reg || recallNow || wrWiper || stepWiper))
    else $error("wiper changed without link command");
  a_drive_low: assert property (!sdaOe_b_reg |->
    state_reg == LINK_ACK || state_reg == LINK_TX)
    else $error("data line driven outside ack or transmit");
  a_stop_idle: assert property (stopSeen && !startSeen |=>
    state_reg == LINK_IDLE && sdaOe_b_reg)
    else $error("stop did not release the link");
  a_step_top: assert property (stepWiper && stepUp && wiperReg[potSel] == `WIPER_MAX
    |=> wiperReg[$past(potSel)] == `WIPER_MAX)
    else $error("step past high end");
endmodule : dual_wiper_register_bank

// ### src/tap_decoder.sv
// one-hot tap switch decoder for both pots
`timescale 1ns/10ps
`include "wiper_bank_regs.svh"
module tap_decoder (
  // clock and reset
  input  logic                   clk,
  input  logic                   rst_b,
  // wiper codes
  wiper_link_if.decoder          link,
  // tap switch enables, bit 0 at the low end terminal
  output logic [`TAP_COUNT-1:0]  tapSelPot0,
  output logic [`TAP_COUNT-1:0]  tapSelPot1
);
  import wiper_bank_pkg::*;

  logic [`TAP_COUNT-1:0] tapSel_reg [2];  // registered switch enables

  // --------------------------------------------------------------------
  // per-pot decode
  // --------------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pot
      // code n closes switch n only; 0 is low end, max is high end
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          tapSel_reg[p] <= `TAP_RESET;
        end else begin
          tapSel_reg[p] <= `TAP_RESET << link.pos[p];
        end
      end

      // never zero or two switches closed
      a_tap_onehot: assert property (@(posedge clk) disable iff (!rst_b)
        $onehot(tapSel_reg[p]))
        else $error("tap enables not one-hot");
      // the closed switch is the one the code names; skip the release edge,
      // where the switches still hold their reset pattern
      a_tap_follows: assert property (@(posedge clk) disable iff (!rst_b)
        $past(rst_b) |-> tapSel_reg[p][$past(link.pos[p])])
        else $error("tap enable does not match wiper code");
    end
  endgenerate

  assign tapSelPot0 = tapSel_reg[0];
  assign tapSelPot1 = tapSel_reg[1];
endmodule : tap_decoder

// ### src/wiper_bank_pkg.sv
// types shared by the wiper register bank modules
`include "wiper_bank_regs.svh"
package wiper_bank_pkg;
  // one wiper position code
  typedef logic [`WIPER_W-1:0] wiper_pos_t;
  // serial link engine states
  typedef enum logic [2:0] {LINK_IDLE, LINK_RX, LINK_ACK, LINK_TX, LINK_TXACK} link_state_t;
  // instruction opcode
  typedef logic [3:0] op_code_t;
endpackage : wiper_bank_pkg

// ### src/wiper_bank_regs.svh
// constants of the dual wiper register bank: field layout, codes, reset values
//
// Operation
// - each pot has its own 6-bit wiper
// - code selects one of 64 taps
// - four 6-bit stored settings per pot
// - power-up copies slot zero into wiper
// - registers written only over serial link
// - master drives serial clock; device follows it
// - data line open drain: pull low or release
// - four select inputs form low four address bits, bit0 LSB
// - address mismatch keeps device idle, line released
// - exactly one tap connected per pot
// - transfer, recall, save and step instructions
`ifndef WIPER_BANK_REGS_SVH
`define WIPER_BANK_REGS_SVH

// --------------------------------------------------------------------
// sizes
// --------------------------------------------------------------------
`define WIPER_W          6
`define TAP_COUNT        64
`define WIPER_MAX        6'h3F

// --------------------------------------------------------------------
// link address and instruction byte layout
// --------------------------------------------------------------------
`define DEV_ADDR_FIXED   3'h2
`define INSTR_OP_MSB     7
`define INSTR_OP_LSB     4
`define INSTR_SLOT_MSB   3
`define INSTR_SLOT_LSB   2
`define INSTR_POT_BIT    0
`define STEP_UP_BIT      0

// --------------------------------------------------------------------
// instruction codes
// --------------------------------------------------------------------
`define OP_STEP          4'h2
`define OP_RD_WIPER      4'h9
`define OP_WR_WIPER      4'hA
`define OP_RD_STORED     4'hB
`define OP_WR_STORED     4'hC
`define OP_RECALL        4'hD
`define OP_SAVE          4'hE

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define STORED_RESET     6'h20
`define WIPER_RESET      6'h20
`define TAP_RESET        64'h0000_0000_0000_0001

`endif

// ### src/wiper_link_if.sv
// wiper positions passed from the register bank to the tap decoder
`timescale 1ns/10ps
interface wiper_link_if;
  import wiper_bank_pkg::*;
  wiper_pos_t pos [2];  // current wiper code per pot
  modport bank    (output pos);
  modport decoder (input  pos);
endinterface : wiper_link_if

// ### verification/link_master.sv
// bus master model that drives the serial link pins
`timescale 1ns/10ps
module link_master (
  // clock
  input  wire logic clk,
  // link pins
  output logic      scl,
  output logic      sdaLow,
  input  wire logic sdaLine
);
  // --------------------------------------------------------------------
  // pin idle state
  // --------------------------------------------------------------------
  // link clock stands high between frames, data released
  initial begin
    scl    = 1'b1;
    sdaLow = 1'b0;
  end

  // --------------------------------------------------------------------
  // bit level tasks, 400 ns link period = 8 clk
  // --------------------------------------------------------------------
  // wait n clk edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // data falls while clock high
  task automatic start_cond();
    @(posedge clk) sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
  endtask : start_cond

  // one bit: data set mid low phase, sampled late in high phase
  task automatic clock_bit(input logic b, output logic s);
    tick(2);
    sdaLow <= ~b;
    tick(2);
    scl <= 1'b1;
    tick(3);
    @(negedge clk) s = sdaLine;
    @(posedge clk) scl <= 1'b0;
  endtask : clock_bit

  // send a byte msb first, release for the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(b[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask : put_byte

  // receive a byte, then acknowledge or not
  task automatic get_byte(input logic mAck, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(~mAck, s);
  endtask : get_byte

  // data rises while clock high, then idle
  task automatic stop_cond();
    tick(2);
    sdaLow <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(4);
  endtask : stop_cond
endmodule : link_master

// ### verification/tb_top.sv
// self-checking testbench of the dual wiper register bank
`timescale 1ns/10ps
`include "wiper_bank_regs.svh"
module tb_top;
  import wiper_bank_pkg::*;
  // --------------------------------------------------------------------
  // signals
  // --------------------------------------------------------------------
  logic                  clk, rst_b, scl, sdaLow, sdaOe_b, sdaOut, ack, quiet;
  logic [3:0]            strap;       // address straps
  logic [7:0]            rb;          // read back byte
  wiper_pos_t            pot0, pot1;  // live wiper codes
  logic [`TAP_COUNT-1:0] tap0, tap1;  // tap enables
  int                    bad_count, total_checks, quietOe;
  // pulled-up line, low when either party pulls
  wire logic sdaLine = ~(sdaLow | (~sdaOe_b & ~sdaOut));

  dual_wiper_register_bank i_dut (.clk(clk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .addrSelectBitZero(strap[0]),
    .addrSelectBitOne(strap[1]), .addrSelectBitTwo(strap[2]), .addrSelectBitThree(strap[3]),
    .wiperPosPot0(pot0), .wiperPosPot1(pot1), .tapSelPot0(tap0), .tapSelPot1(tap1));
  link_master i_master (.clk(clk), .scl(scl), .sdaLow(sdaLow), .sdaLine(sdaLine));

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // instruction byte from opcode, slot and pot
  function automatic logic [7:0] ins(input op_code_t op, input logic [1:0] s, input logic p);
    return {op, s, 1'b0, p};
  endfunction : ins

  // write frame: address, instruction, optional data byte
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input bit hasDat);
    i_master.start_cond();
    i_master.put_byte({`DEV_ADDR_FIXED, strap, 1'b0}, ack);
    check(ack, 1'b1);
    i_master.put_byte(i, ack);
    check(ack, 1'b1);
    if (hasDat) begin
      i_master.put_byte(d, ack);
      check(ack, 1'b1);
    end
    i_master.stop_cond();
  endtask : wr

  // read frame: one byte, master declines more
  task automatic rd(output logic [7:0] b);
    i_master.start_cond();
    i_master.put_byte({`DEV_ADDR_FIXED, strap, 1'b1}, ack);
    check(ack, 1'b1);
    i_master.get_byte(1'b0, b);
    i_master.stop_cond();
  endtask : rd

  // both wipers and their one-hot taps
  task automatic chk_pots(input wiper_pos_t e0, input wiper_pos_t e1);
    check(pot0, e0);
    check(pot1, e1);
    check(tap0, 64'h1 << e0);
    check(tap1, 64'h1 << e1);
  endtask : chk_pots

  // print counts and verdict, end the run
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // --------------------------------------------------------------------
  // clock, monitors, watchdog
  // --------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // open drain only pulls low; no drive while not addressed
  always @(posedge clk) begin
    if (sdaOe_b === 1'b0) check(sdaOut, 1'b0);
    if (quiet && sdaOe_b !== 1'b1) quietOe++;
  end
  // cut a hang short
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    finish_test();
  end

  // --------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    strap = 4'hA;
    quiet = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk_pots(`STORED_RESET, `STORED_RESET);
    // both ends of the tap range, top data bits ignored
    wr(ins(`OP_WR_WIPER, 2'h0, 1'b0), 8'hC0, 1);
    wr(ins(`OP_WR_WIPER, 2'h0, 1'b1), 8'h3F, 1);
    chk_pots(6'h00, 6'h3F);
    // four stored slots of pot1, slot 0 of pot0 untouched
    for (int s = 0; s < 4; s++) wr(ins(`OP_WR_STORED, 2'(s), 1'b1), 8'h11 + 8'(s), 1);
    for (int s = 0; s < 4; s++) begin
      wr(ins(`OP_RD_STORED, 2'(s), 1'b1), 8'h00, 0);
      rd(rb);
      check(rb, 8'h11 + 8'(s));
    end
    wr(ins(`OP_RD_STORED, 2'h0, 1'b0), 8'h00, 0);
    rd(rb);
    check(rb, 8'h20);
    // recall, save, step with saturation, read wiper
    wr(ins(`OP_RECALL, 2'h2, 1'b1), 8'h00, 0);
    chk_pots(6'h00, 6'h13);
    wr(ins(`OP_SAVE, 2'h3, 1'b0), 8'h00, 0);
    wr(ins(`OP_RD_STORED, 2'h3, 1'b0), 8'h00, 0);
    rd(rb);
    check(rb, 8'h00);
    wr(ins(`OP_STEP, 2'h0, 1'b0), 8'h00, 1);
    wr(ins(`OP_STEP, 2'h0, 1'b0), 8'h01, 1);
    wr(ins(`OP_WR_WIPER, 2'h0, 1'b1), 8'h3F, 1);
    wr(ins(`OP_STEP, 2'h0, 1'b1), 8'h01, 1);
    chk_pots(6'h01, 6'h3F);
    wr(ins(`OP_RD_WIPER, 2'h0, 1'b1), 8'h00, 0);
    rd(rb);
    check(rb, 8'h3F);
    // each strap bit wrong in turn: no answer, no change
    quiet = 1'b1;
    for (int b = 0; b < 4; b++) begin
      i_master.start_cond();
      i_master.put_byte({`DEV_ADDR_FIXED, strap ^ (4'h1 << b), 1'b0}, ack);
      check(ack, 1'b0);
      i_master.put_byte(ins(`OP_WR_WIPER, 2'h0, 1'b0), ack);
      i_master.put_byte(8'h2A, ack);
      i_master.stop_cond();
    end
    quiet = 1'b0;
    check(quietOe, 0);
    chk_pots(6'h01, 6'h3F);
    // new strap value takes effect
    @(posedge clk) strap <= 4'h5;
    repeat (4) @(posedge clk);
    wr(ins(`OP_WR_WIPER, 2'h0, 1'b0), 8'h2A, 1);
    chk_pots(6'h2A, 6'h3F);
    // second reset reloads slot zero
    @(posedge clk) rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk_pots(`STORED_RESET, `STORED_RESET);
    finish_test();
  end
endmodule : tb_top
